// file: hw/sdtc_core.sv
// area wait states, sdram command spacing and timing register block
//
// Notes on behaviour
// - area 2 ordinary memory: codes 0..3 insert 0..3 waits; wait pin off at 0
// - area 0 first cycle waits 0,1,2,3,4,6,8,10; wait pin off at 0
// - area 0 burst beats take 2,2,3,4,4,6,8,10 states; wait pin honoured
// - timing register clears on power-on reset, survives manual reset
// - precharge to activate gap is 1..4 cycles normally
// - gap is one shorter right after all-bank or bank-active precharge
// - after self-refresh exit wait 2,5,8,11 cycles before activate
// - activate to read or write delay is 1..4 cycles
// - after a write, activate waits precharge gap plus write recovery
// - after auto-refresh, activate waits precharge gap plus hold-off
// - bank policy bit: 0 auto-precharge, 1 rows stay open
// - bits 6..3 choose the row/column address split
// - split codes set the row start bit; other codes prohibited
// - refresh enable bit: 0 off, 1 on
// - mode 0 auto-refresh after current cycle; mode 1 self-refresh
// - bit 0 reads zero, writes ignored
//
// Implementation choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module sdtc_core
  import sdtc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic manual_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic acc_valid,
  input wire sdtc_pkg::sdtc_acc_t acc,
  output logic acc_ready,
  output logic beat_done,
  input wire logic wait_n,
  input wire logic bus_wide,
  input wire logic refresh_tick,
  output logic mem_strobe,
  output sdtc_pkg::sdtc_sd_t sd,
  output logic self_refresh
);

  typedef enum logic [2:0] {
    S_IDLE, S_ORD, S_SD_ACT, S_SD_RCD, S_SD_CAS, S_SELF
  } sdtc_state_t;

  sdtc_state_t state_q;
  logic [15:0] wait_q;
  logic [15:0] timing_q;
  logic [31:0] wb_dat_q;
  logic wb_ack_q;
  sdtc_acc_t acc_q;
  sdtc_sd_t sd_q;
  logic acc_ready_q;
  logic beat_done_q;
  logic mem_strobe_q;
  logic self_q;
  logic [GAP_W-1:0] cnt_q;
  logic xwait_en_q;
  logic row_open_q;
  logic last_wr_q;
  logic [ROW_W-1:0] open_row_q;
  logic ref_pend_q;
  logic gap_load_q;
  logic [GAP_W-1:0] gap_val_q;
  logic gap_ready;
  logic [ROW_W-1:0] row;
  logic [ROW_W-1:0] col;
  logic split_bad;

  ////////////////////////////////////////////////////////////////////////////
  // field views

  logic [1:0] tpc;
  logic [1:0] rcd;
  logic [1:0] trwl;
  logic [1:0] tras;
  logic bank_mode;
  logic ref_en;
  logic rkind;
  logic [2:0] a0w;
  logic [1:0] a2w;
  logic [1:0] a3w;
  logic [GAP_W-1:0] gap_norm;
  logic [GAP_W-1:0] gap_short;
  logic [GAP_W-1:0] wr_rec;
  logic [GAP_W-1:0] ref_hold;
  logic want_self;
  logic want_ref;
  logic acc_take;
  logic [GAP_W-1:0] ord_first;
  logic ord_wait_en;
  logic [GAP_W-1:0] ord_pitch;
  logic [GAP_W-1:0] cas_now;
  logic [ACC_ADDR_W-1:0] step;

  assign tpc = timing_q[TPC_LSB +: 2];
  assign rcd = timing_q[RCD_LSB +: 2];
  assign trwl = timing_q[TRWL_LSB +: 2];
  assign tras = timing_q[TRAS_LSB +: 2];
  assign bank_mode = timing_q[BANK_HOLD_BIT];
  assign ref_en = timing_q[REF_EN_BIT];
  assign rkind = timing_q[REF_KIND_BIT];
  assign a0w = wait_q[A0W_LSB +: 3];
  assign a2w = wait_q[A2W_LSB +: 2];
  assign a3w = wait_q[A3W_LSB +: 2];

  always_comb
  begin
    gap_norm = GAP_W'(tpc) + 5'd1;
    gap_short = GAP_W'(tpc);
    wr_rec = GAP_W'(trwl) + 5'd1;
    ref_hold = GAP_W'(tras) + 5'd2;
    want_self = ref_en && rkind;
    want_ref = ref_pend_q && ref_en && !rkind;
    acc_take = (state_q == S_IDLE) && acc_ready_q && acc_valid;
    step = bus_wide ? 26'h000_0004 : 26'h000_0002;
    // area 0 uses the 3-bit code, area 2 the 2-bit code
    if (acc.area == 2'd0)
    begin
      ord_first = first_waits(a0w);
      ord_wait_en = (a0w != 3'h0);
    end
    else if (acc.area == 2'd2)
    begin
      ord_first = GAP_W'(a2w);
      ord_wait_en = (a2w != 2'h0);
    end
    else
    begin
      ord_first = 5'd0;
      ord_wait_en = 1'b1;
    end
    if (acc_q.area == 2'd0)
      ord_pitch = burst_states(a0w) - 5'd1;
    else
      ord_pitch = GAP_W'(a2w);
    if (acc_q.area == 2'd3)
      cas_now = cas_cycles(a3w);
    else
      cas_now = cas_cycles(a2w);
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone register slave, one wait state, unmapped reads return zero

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wait_q <= WAIT_RESET;
      timing_q <= TIMING_RESET;
      wb_ack_q <= 1'b0;
      wb_dat_q <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_q <= wb_cyc_i && wb_stb_i && !wb_ack_q;
      if (wb_cyc_i && wb_stb_i && !wb_ack_q && wb_we_i)
      begin
        if (wb_adr_i == OFF_WAIT)
        begin
          if (wb_sel_i[0]) wait_q[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) wait_q[15:8] <= wb_dat_i[15:8];
        end
        else if (wb_adr_i == OFF_TIMING)
        begin
          if (wb_sel_i[0]) timing_q[7:1] <= wb_dat_i[7:1];
          if (wb_sel_i[1]) timing_q[15:8] <= wb_dat_i[15:8];
        end
      end
      else if (wb_cyc_i && wb_stb_i && !wb_ack_q)
      begin
        if (wb_adr_i == OFF_WAIT)
          wb_dat_q <= {16'h0000, wait_q};
        else if (wb_adr_i == OFF_TIMING)
          wb_dat_q <= {16'h0000, timing_q[15:1], 1'b0};
        else if (wb_adr_i == OFF_STATUS)
          wb_dat_q <= {27'h000_0000, split_bad, ref_pend_q, row_open_q,
                       self_q, (state_q != S_IDLE)};
        else
          wb_dat_q <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // refresh request latch; a tick in the clearing cycle is kept

  logic ref_issue;
  assign ref_issue = (state_q == S_IDLE) && !acc_take && !want_self &&
                     want_ref && !row_open_q && gap_ready;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      ref_pend_q <= 1'b0;
    else if (manual_rst)
      ref_pend_q <= 1'b0;
    else if (refresh_tick && ref_en && !rkind)
      ref_pend_q <= 1'b1;
    else if (ref_issue || !ref_en || rkind)
      ref_pend_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // access and sdram command sequencer

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_q <= S_IDLE;
      acc_q <= '0;
      sd_q <= '0;
      acc_ready_q <= 1'b0;
      beat_done_q <= 1'b0;
      mem_strobe_q <= 1'b0;
      self_q <= 1'b0;
      cnt_q <= '0;
      xwait_en_q <= 1'b0;
      row_open_q <= 1'b0;
      last_wr_q <= 1'b0;
      open_row_q <= '0;
      gap_load_q <= 1'b0;
      gap_val_q <= '0;
    end
    else if (manual_rst)
    begin
      state_q <= S_IDLE;
      sd_q <= '0;
      acc_ready_q <= 1'b0;
      beat_done_q <= 1'b0;
      mem_strobe_q <= 1'b0;
      self_q <= 1'b0;
      row_open_q <= 1'b0;
      gap_load_q <= 1'b0;
    end
    else
    begin
      beat_done_q <= 1'b0;
      gap_load_q <= 1'b0;
      acc_ready_q <= 1'b0;
      sd_q.cmd <= CMD_NOP;
      case (state_q)
        S_IDLE:
        begin
          if (acc_take)
          begin
            acc_q <= acc;
            if (acc.sdram)
              state_q <= S_SD_ACT;
            else
            begin
              state_q <= S_ORD;
              mem_strobe_q <= 1'b1;
              cnt_q <= ord_first;
              xwait_en_q <= ord_wait_en;
            end
          end
          else if (want_self || want_ref)
          begin
            if (row_open_q)
            begin
              sd_q.cmd <= CMD_ALL_BANK_CLOSE;
              row_open_q <= 1'b0;
              gap_load_q <= 1'b1;
              gap_val_q <= gap_short;
            end
            else if (gap_ready && want_self)
            begin
              sd_q.cmd <= CMD_SELF_ENTER;
              self_q <= 1'b1;
              state_q <= S_SELF;
            end
            else if (gap_ready)
            begin
              sd_q.cmd <= CMD_AUTO_REFRESH;
              gap_load_q <= 1'b1;
              gap_val_q <= gap_norm + ref_hold;
            end
          end
          else
            acc_ready_q <= 1'b1;
        end
        S_ORD:
        begin
          if (cnt_q != '0)
            cnt_q <= cnt_q - 5'd1;
          else if (xwait_en_q && !wait_n)
            cnt_q <= '0;
          else
          begin
            beat_done_q <= 1'b1;
            if (acc_q.beats != 2'd0)
            begin
              acc_q.beats <= acc_q.beats - 2'd1;
              cnt_q <= ord_pitch;
              xwait_en_q <= 1'b1;
            end
            else
            begin
              mem_strobe_q <= 1'b0;
              state_q <= S_IDLE;
            end
          end
        end
        S_SD_ACT:
        begin
          if (row_open_q && row == open_row_q)
          begin
            cnt_q <= '0;
            state_q <= S_SD_RCD;
          end
          else if (row_open_q)
          begin
            sd_q.cmd <= CMD_PRECHARGE;
            row_open_q <= 1'b0;
            gap_load_q <= 1'b1;
            gap_val_q <= last_wr_q ? gap_short + wr_rec : gap_short;
          end
          else if (gap_ready)
          begin
            sd_q.cmd <= CMD_ACTIVATE;
            sd_q.addr <= row;
            open_row_q <= row;
            row_open_q <= bank_mode;
            cnt_q <= GAP_W'(rcd);
            state_q <= S_SD_RCD;
          end
        end
        S_SD_RCD:
        begin
          if (cnt_q != '0)
            cnt_q <= cnt_q - 5'd1;
          else
          begin
            sd_q.cmd <= acc_q.write ? CMD_WRITE : CMD_READ;
            sd_q.addr <= col;
            sd_q.auto_pre <= !bank_mode && (acc_q.beats == 2'd0);
            last_wr_q <= acc_q.write;
            if (!acc_q.write)
            begin
              cnt_q <= cas_now - 5'd1;
              state_q <= S_SD_CAS;
            end
            else
            begin
              beat_done_q <= 1'b1;
              if (acc_q.beats != 2'd0)
              begin
                acc_q.beats <= acc_q.beats - 2'd1;
                acc_q.addr <= acc_q.addr + step;
              end
              else
              begin
                state_q <= S_IDLE;
                gap_load_q <= !bank_mode;
                gap_val_q <= gap_norm + wr_rec;
              end
            end
          end
        end
        S_SD_CAS:
        begin
          if (cnt_q != '0)
            cnt_q <= cnt_q - 5'd1;
          else
          begin
            beat_done_q <= 1'b1;
            if (acc_q.beats != 2'd0)
            begin
              acc_q.beats <= acc_q.beats - 2'd1;
              acc_q.addr <= acc_q.addr + step;
              state_q <= S_SD_RCD;
            end
            else
            begin
              state_q <= S_IDLE;
              gap_load_q <= !bank_mode;
              gap_val_q <= gap_norm;
            end
          end
        end
        S_SELF:
        begin
          if (!want_self)
          begin
            sd_q.cmd <= CMD_SELF_EXIT;
            self_q <= 1'b0;
            gap_load_q <= 1'b1;
            gap_val_q <= self_exit_gap(tpc);
            state_q <= S_IDLE;
          end
        end
        default:
          state_q <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers and outputs

  sdtc_gap_timer #(
    .W(GAP_W)
  ) u_gap (
    .clock(clock),
    .rst(rst),
    .clear(manual_rst),
    .load(gap_load_q),
    .value(gap_val_q),
    .ready(gap_ready)
  );

  sdtc_addr_split u_split (
    .addr(acc_q.addr),
    .code(timing_q[AMX_LSB +: 4]),
    .wide(bus_wide),
    .row(row),
    .col(col),
    .bad(split_bad)
  );

  assign wb_dat_o = wb_dat_q;
  assign wb_ack_o = wb_ack_q;
  assign acc_ready = acc_ready_q;
  assign beat_done = beat_done_q;
  assign mem_strobe = mem_strobe_q;
  assign sd = sd_q;
  assign self_refresh = self_q;

endmodule // sdtc_core

// file: hw/sdtc_pkg.sv
// shared constants, types and decode functions for the sdram timing block
package sdtc_pkg;

  localparam int ACC_ADDR_W = 26;
  localparam int ROW_W = 15;
  localparam int GAP_W = 5;

  // register byte offsets on the wishbone bus
  localparam logic [7:0] OFF_WAIT = 8'h00;
  localparam logic [7:0] OFF_TIMING = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;

  localparam logic [15:0] WAIT_RESET = 16'hffff;
  localparam logic [15:0] TIMING_RESET = 16'h0000;

  // area_wait_control_two field positions
  localparam int A0W_LSB = 0;
  localparam int A2W_LSB = 3;
  localparam int A3W_LSB = 5;
  // sdram_timing_control field positions
  localparam int TPC_LSB = 14;
  localparam int RCD_LSB = 12;
  localparam int TRWL_LSB = 10;
  localparam int TRAS_LSB = 8;
  localparam int BANK_HOLD_BIT = 7;
  localparam int AMX_LSB = 3;
  localparam int REF_EN_BIT = 2;
  localparam int REF_KIND_BIT = 1;
  localparam int RSVD_BIT = 0;

  typedef enum logic [3:0] {
    CMD_NOP, CMD_ACTIVATE, CMD_READ, CMD_WRITE, CMD_PRECHARGE,
    CMD_ALL_BANK_CLOSE, CMD_AUTO_REFRESH, CMD_SELF_ENTER, CMD_SELF_EXIT
  } sdtc_cmd_t;

  typedef struct packed {
    logic write;
    logic sdram;
    logic [1:0] area;
    logic [1:0] beats;
    logic [ACC_ADDR_W-1:0] addr;
  } sdtc_acc_t;

  typedef struct packed {
    sdtc_cmd_t cmd;
    logic auto_pre;
    logic [ROW_W-1:0] addr;
  } sdtc_sd_t;

  function automatic logic [GAP_W-1:0] first_waits(input logic [2:0] c);
    case (c)
      3'h0: first_waits = 5'd0;
      3'h1: first_waits = 5'd1;
      3'h2: first_waits = 5'd2;
      3'h3: first_waits = 5'd3;
      3'h4: first_waits = 5'd4;
      3'h5: first_waits = 5'd6;
      3'h6: first_waits = 5'd8;
      default: first_waits = 5'd10;
    endcase
  endfunction

  function automatic logic [GAP_W-1:0] burst_states(input logic [2:0] c);
    case (c)
      3'h0, 3'h1: burst_states = 5'd2;
      3'h2: burst_states = 5'd3;
      3'h3, 3'h4: burst_states = 5'd4;
      3'h5: burst_states = 5'd6;
      3'h6: burst_states = 5'd8;
      default: burst_states = 5'd10;
    endcase
  endfunction

  function automatic logic [GAP_W-1:0] cas_cycles(input logic [1:0] c);
    case (c)
      2'h0, 2'h1: cas_cycles = 5'd1;
      2'h2: cas_cycles = 5'd2;
      default: cas_cycles = 5'd3;
    endcase
  endfunction

  function automatic logic [GAP_W-1:0] self_exit_gap(input logic [1:0] c);
    case (c)
      2'h0: self_exit_gap = 5'd2;
      2'h1: self_exit_gap = 5'd5;
      2'h2: self_exit_gap = 5'd8;
      default: self_exit_gap = 5'd11;
    endcase
  endfunction

endpackage

// file: hw/sdtc_gap_timer.sv
// minimum-spacing down counter that gates the next bank activate
`timescale 1ns/1ps
module sdtc_gap_timer
#(
  parameter int W = 5
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic clear,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic ready
);

  // the longest spacing loaded is 11 cycles, so four bits are the floor
  if (W < 4)
  begin : g_bad_width
    $error("sdtc_gap_timer: W too narrow for the longest spacing");
  end

  logic [W-1:0] cnt_q;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      cnt_q <= '0;
    else if (clear)
      cnt_q <= '0;
    else if (load)
      cnt_q <= value;
    else if (cnt_q != '0)
      cnt_q <= cnt_q - 1'b1;
  end

  // a load in flight blocks so the spacing never reads a stale zero
  assign ready = (cnt_q == '0) && !load;

endmodule // sdtc_gap_timer

// file: hw/sdtc_addr_split.sv
// splits an access address into sdram row and column parts
`timescale 1ns/1ps
module sdtc_addr_split
  import sdtc_pkg::*;
(
  input wire logic [sdtc_pkg::ACC_ADDR_W-1:0] addr,
  input wire logic [3:0] code,
  input wire logic wide,
  output logic [sdtc_pkg::ROW_W-1:0] row,
  output logic [sdtc_pkg::ROW_W-1:0] col,
  output logic bad
);

  logic [3:0] start;
  logic [ACC_ADDR_W-1:0] low_mask;

  always_comb
  begin
    bad = 1'b0;
    case (code)
      4'hd: start = 4'd10;
      4'he:
      begin
        start = 4'd11;
        bad = wide;
      end
      4'h4: start = 4'd9;
      4'h5: start = 4'd10;
      4'h7:
      begin
        start = 4'd9;
        bad = !wide;
      end
      default:
      begin
        start = 4'd10;
        bad = 1'b1;
      end
    endcase
  end

  always_comb
  begin
    low_mask = ~({ACC_ADDR_W{1'b1}} << start);
    row = ROW_W'(addr >> start);
    col = ROW_W'((addr & low_mask) >> (wide ? 2 : 1));
  end

endmodule // sdtc_addr_split

// file: sim/sdtc_core_props.sv
// port-level assertions for the sdram timing block
`timescale 1ns/1ps
module sdtc_core_props
  import sdtc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic acc_ready,
  input wire sdtc_pkg::sdtc_sd_t sd,
  input wire logic self_refresh
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [15:0] tim_q;
  logic seen_q;
  logic [7:0] pre_q, act_q, wr_q, ref_q, sx_q;
  logic wr_tim;
  logic [7:0] tpc, rcd, trwl, tras;
  assign wr_tim = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
    && wb_adr_i == OFF_TIMING;
  assign tpc = {6'h00, tim_q[15:14]};
  assign rcd = {6'h00, tim_q[13:12]};
  assign trwl = {6'h00, tim_q[11:10]};
  assign tras = {6'h00, tim_q[9:8]};
  // shadow of the timing register, survives manual reset like the real one
  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      tim_q <= 16'h0000;
      seen_q <= 1'b0;
    end
    else if (wr_tim)
    begin
      if (wb_sel_i[0]) tim_q[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1]) tim_q[15:8] <= wb_dat_i[15:8];
      seen_q <= 1'b1;
    end
  function automatic logic [7:0] age(logic [7:0] v, logic hit);
    return hit ? 8'h01 : (v == 8'hff ? v : v + 8'h01);
  endfunction
  // cycles since the last precharge, activate, write, auto-refresh and self-exit; start saturated so nothing fires early
  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      pre_q <= 8'hff;
      act_q <= 8'hff;
      wr_q <= 8'hff;
      ref_q <= 8'hff;
      sx_q <= 8'hff;
    end
    else
    begin
      pre_q <= age(pre_q, sd.cmd == CMD_PRECHARGE
        || sd.cmd == CMD_ALL_BANK_CLOSE);
      act_q <= age(act_q, sd.cmd == CMD_ACTIVATE);
      wr_q <= age(wr_q, sd.cmd == CMD_WRITE);
      ref_q <= age(ref_q, sd.cmd == CMD_AUTO_REFRESH);
      sx_q <= age(sx_q, sd.cmd == CMD_SELF_EXIT);
    end
  a_act_to_col: assert property (
    sd.cmd == CMD_READ || sd.cmd == CMD_WRITE |-> act_q >= rcd + 8'h01)
    else $error("column command too soon after activate");
  a_pre_to_act: assert property (
    sd.cmd == CMD_ACTIVATE |-> pre_q >= tpc + 8'h01)
    else $error("activate too soon after precharge");
  a_self_exit_gap: assert property (
    sd.cmd == CMD_ACTIVATE |-> sx_q >= tpc * 8'h03 + 8'h02)
    else $error("activate too soon after self-refresh exit");
  a_write_recov: assert property (
    sd.cmd == CMD_ACTIVATE |-> wr_q >= tpc + trwl + 8'h02)
    else $error("activate too soon after write");
  a_refresh_hold: assert property (
    sd.cmd == CMD_ACTIVATE |-> ref_q >= tpc + tras + 8'h03)
    else $error("activate too soon after auto-refresh");
  a_self_quiet: assert property (
    self_refresh |-> !acc_ready && sd.cmd != CMD_ACTIVATE
      && sd.cmd != CMD_AUTO_REFRESH)
    else $error("activity while in self-refresh");
  a_bank_no_auto: assert property (
    (sd.cmd == CMD_READ || sd.cmd == CMD_WRITE) && tim_q[7]
      |-> !sd.auto_pre)
    else $error("auto-precharge issued in bank-active mode");
  a_rsvd_zero: assert property (
    $rose(wb_ack_o) && !wb_we_i && wb_adr_i == OFF_TIMING
      |-> wb_dat_o[0] == 1'b0)
    else $error("reserved timing bit read as one");
  a_reset_val: assert property (
    $rose(wb_ack_o) && !wb_we_i && wb_adr_i == OFF_TIMING && !seen_q
      |-> wb_dat_o[15:0] == 16'h0000)
    else $error("timing register not clear after power-on");
endmodule // sdtc_core_props

// file: sim/sdtc_mem_model.sv
// far-side memory: stretches the wait line, counts refresh commands
`timescale 1ns/1ps
module sdtc_mem_model
  import sdtc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic mem_strobe,
  input wire sdtc_pkg::sdtc_sd_t sd,
  input wire logic [3:0] stall,
  output logic wait_n,
  output logic [7:0] ref_cnt
);
  logic [3:0] left_q;
  logic strobe_q;
  // a slow device holds wait low for stall cycles after the cycle starts
  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      left_q <= 4'h0;
      strobe_q <= 1'b0;
      wait_n <= 1'b1;
    end
    else
    begin
      strobe_q <= mem_strobe;
      if (mem_strobe && !strobe_q && stall != 4'h0)
        left_q <= stall;
      else if (left_q != 4'h0)
        left_q <= left_q - 4'h1;
      wait_n <= !(mem_strobe && !strobe_q && stall != 4'h0)
        && left_q <= 4'h1;
    end
  always_ff @(posedge clock or posedge rst)
    if (rst)
      ref_cnt <= 8'h00;
    else if (sd.cmd == CMD_AUTO_REFRESH)
      ref_cnt <= ref_cnt + 8'h01;
endmodule // sdtc_mem_model

// file: sim/test_sdtc_core.sv
// self-checking bench for the sdram timing block
`timescale 1ns/1ps
module test_sdtc_core
  import sdtc_pkg::*;
;
  logic clock = 1'b0, rst = 1'b1, manual_rst = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
  logic wb_ack_o, acc_ready, beat_done, wait_n, mem_strobe, self_refresh;
  logic acc_valid = 1'b0, bus_wide = 1'b1, refresh_tick = 1'b0;
  sdtc_acc_t acc = '0;
  sdtc_sd_t sd, col_cmd;
  logic [3:0] stall = 4'h0;
  logic [7:0] ref_cnt;
  logic [31:0] rd;
  int error_cnt = 0, checks_done = 0;
  int fw[8] = '{0, 1, 2, 3, 4, 6, 8, 10};
  int bs[8] = '{2, 2, 3, 4, 4, 6, 8, 10};
  int cl[4] = '{1, 1, 2, 3};
  always #2.5 clock = ~clock;
  sdtc_core u_dut (.clock, .rst, .manual_rst, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .acc_valid, .acc, .acc_ready, .beat_done, .wait_n, .bus_wide,
    .refresh_tick, .mem_strobe, .sd, .self_refresh);
  sdtc_mem_model u_mem (.clock, .rst, .mem_strobe, .sd, .stall, .wait_n,
    .ref_cnt);
  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // the model holds wait low up to edge 7, so a slow first beat lands at 9
  function automatic int first_beat(input int w, input logic slow_dev);
    return (slow_dev && w < 7) ? 9 : w + 2;
  endfunction
  task automatic tmo();
    error_cnt++;
    end_of_test();
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one classic cycle; request held until ack is sampled, then one idle
  task automatic wb(input logic we, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 40);
    if (n >= 40) tmo();
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clock);
  endtask
  // one access; edge counts from the take edge to beats and column command
  task automatic go(input logic w, s, input logic [1:0] ar, b,
    output int n1, n2, nc);
    int n, k;
    n = 0;
    acc_valid <= 1'b1;
    acc <= '{w, s, ar, b, 26'h000_0100};
    do
    begin
      @(posedge clock);
      n++;
    end
    while (acc_ready !== 1'b1 && n < 400);
    if (n >= 400) tmo();
    acc_valid <= 1'b0;
    n1 = 0;
    n2 = 0;
    nc = 0;
    k = 0;
    for (n = 1; n < 400 && k <= b; n++)
    begin
      @(posedge clock);
      if (sd.cmd === CMD_READ || sd.cmd === CMD_WRITE)
      begin
        nc = n;
        col_cmd = sd;
      end
      if (beat_done === 1'b1)
      begin
        k++;
        if (k == 1) n1 = n;
        else n2 = n;
      end
    end
    if (k <= b) tmo();
  endtask
  task automatic tick(input logic [7:0] inc);
    logic [7:0] c0;
    int n;
    c0 = ref_cnt;
    refresh_tick <= 1'b1;
    @(posedge clock);
    refresh_tick <= 1'b0;
    for (n = 0; n < 40 && ref_cnt === c0; n++) @(posedge clock);
    chk(ref_cnt, c0 + inc);
  endtask
  task automatic wait_self(input logic v);
    int n;
    for (n = 0; n < 200 && self_refresh !== v; n++) @(posedge clock);
    chk(self_refresh, v);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    wb(1'b0, OFF_WAIT, 0);
    chk(rd, 32'h0000_ffff);
    wb(1'b0, OFF_TIMING, 0);
    chk(rd, 32'h0000_0000);
    wb(1'b0, 8'h0c, 0);
    chk(rd, 32'h0000_0000);
    wb(1'b1, OFF_TIMING, 32'h0000_2a2b);
    wb(1'b0, OFF_TIMING, 0);
    chk(rd, 32'h0000_2a2a);
    manual_rst <= 1'b1;
    @(posedge clock);
    manual_rst <= 1'b0;
    @(posedge clock);
    wb(1'b0, OFF_TIMING, 0);
    chk(rd, 32'h0000_2a2a);
    $display("test regs done");
  endtask
  task automatic t_plain();
    int c, s, n1, n2, nc;
    for (s = 0; s < 2; s++)
      for (c = 0; c < 8; c++)
      begin
        stall <= s ? 4'h6 : 4'h0;
        wb(1'b1, OFF_WAIT, {16'h0, 11'h7ff, c[1:0], c[2:0]});
        go(1'b0, 1'b0, 2'd0, 2'd1, n1, n2, nc);
        chk(n1, first_beat(fw[c], s != 0 && c != 0));
        if (s == 0) chk(n2 - n1, bs[c]);
        go(1'b0, 1'b0, 2'd2, 2'd0, n1, n2, nc);
        chk(n1, first_beat(c[1:0], s != 0 && c[1:0] != 0));
      end
    stall <= 4'h0;
    $display("test ordinary memory done");
  endtask
  task automatic t_sdram();
    int c, n1, n2, nc;
    wb(1'b1, OFF_TIMING, 32'h0000_5528);
    for (c = 0; c < 4; c++)
    begin
      wb(1'b1, OFF_WAIT, {16'h0, 11'h7ff, c[1:0], 3'h0});
      go(1'b0, 1'b1, 2'd2, 2'd0, n1, n2, nc);
      chk(n1 - nc, cl[c]);
      chk(col_cmd.auto_pre, 1'b1);
      go(1'b1, 1'b1, 2'd2, 2'd0, n1, n2, nc);
      chk(n1 - nc, 0);
    end
    wb(1'b0, OFF_STATUS, 0);
    chk(rd[4], 1'b0);
    wb(1'b1, OFF_TIMING, 32'h0000_5578);
    wb(1'b0, OFF_STATUS, 0);
    chk(rd[4], 1'b1);
    // bank-active: row stays open, a repeat hit skips the activate
    wb(1'b1, OFF_TIMING, 32'h0000_95a8);
    go(1'b0, 1'b1, 2'd2, 2'd0, n1, n2, nc);
    chk(col_cmd.auto_pre, 1'b0);
    go(1'b0, 1'b1, 2'd2, 2'd0, n1, n2, nc);
    chk(nc, 3);
    wb(1'b1, OFF_TIMING, 32'h0000_95ac);
    tick(8'h01);
    wb(1'b1, OFF_TIMING, 32'h0000_5528);
    $display("test sdram done");
  endtask
  task automatic t_refresh();
    int n1, n2, nc;
    tick(8'h00);
    wb(1'b1, OFF_TIMING, 32'h0000_552c);
    tick(8'h01);
    go(1'b0, 1'b1, 2'd2, 2'd0, n1, n2, nc);
    wb(1'b1, OFF_TIMING, 32'h0000_552e);
    wait_self(1'b1);
    chk(acc_ready, 1'b0);
    tick(8'h00);
    wb(1'b1, OFF_TIMING, 32'h0000_5528);
    wait_self(1'b0);
    go(1'b1, 1'b1, 2'd2, 2'd0, n1, n2, nc);
    chk(n1 - nc, 0);
    $display("test refresh done");
  endtask
  initial
  begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_regs();
    t_plain();
    t_sdram();
    t_refresh();
    end_of_test();
  end
endmodule // test_sdtc_core
bind sdtc_core sdtc_core_props u_props (.clock, .rst, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
  .wb_ack_o, .acc_ready, .sd, .self_refresh);
